// ### hdl/vpg_top.sv
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/100ps
// vpg_top: apb register file, line timing, group configuration and output routing
// assumes: line_start and field_start are one-cycle pulses synchronous to mclk (10 MHz)
module vpg_top (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // line timing from the h/v counters
  input  wire logic        line_start,
  input  wire logic        field_start,
  // to the vertical driver channels
  output logic      [7:0]  vout,
  output logic             hblank
);
  logic [31:0] mem_reg [vpg_pkg::NUM_WORDS];
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic [12:0] pix_reg;
  logic        line_odd_reg;
  logic [1:0]  phase_reg;
  logic [7:0]  vout_reg;
  logic        hblank_reg;
  logic [5:0]  ix;
  logic        mapped;
  logic        setup;
  logic        wr_go;
  logic        segment_alternation_mode;
  logic        merge;
  logic        hold;
  logic [3:0]  flen_en;
  logic [1:0]  alt_last;
  logic [7:0]  pol;
  logic [1:0]  pick [vpg_pkg::NUM_GRP];
  logic [1:0]  asg [vpg_pkg::NUM_OUT];
  logic [17:0] sel_w [4];
  logic [17:0] sel0;
  logic [17:0] sel1;
  logic [1:0]  a_code;
  logic [3:0]  lvl_v;
  logic [12:0] a_rep_idx;
  logic [31:0] rd_word;

  // writable bits of each word; the rest store and read as zero
  function automatic logic [31:0] wmask(input logic [5:0] i);
    logic [31:0] m;
    m = vpg_pkg::RST_WORD;
    if (i == vpg_pkg::IX_CTRL0) m = vpg_pkg::MSK_CTRL0;
    else if (i == vpg_pkg::IX_ASSIGN || i == vpg_pkg::IX_PICK) m = vpg_pkg::MSK_LO16;
    else if (i == vpg_pkg::IX_A_REP34) m = vpg_pkg::MSK_PAIR;
    else if (i >= vpg_pkg::IX_GRP && i < vpg_pkg::IX_PAT) begin
      if (i[1:0] == 2'b00) m = vpg_pkg::MSK_POS;
      else if (i[1:0] != 2'b11) m = vpg_pkg::MSK_PAIR;
    end
    else if (i >= vpg_pkg::IX_PAT && i < vpg_pkg::IX_FRZ) m = vpg_pkg::MSK_PAIR;
    else if (i >= vpg_pkg::IX_FRZ && i < vpg_pkg::IX_HB_EVEN) m = vpg_pkg::MSK_POS;
    else if (i == vpg_pkg::IX_HB_EVEN || i == vpg_pkg::IX_HB_ODD) m = vpg_pkg::MSK_PAIR;
    return m;
  endfunction

  function automatic logic [12:0] lo13(input logic [31:0] w);
    return w[vpg_pkg::POS_W-1:0];
  endfunction

  function automatic logic [12:0] hi13(input logic [31:0] w);
    return w[vpg_pkg::HI_LSB +: vpg_pkg::POS_W];
  endfunction

  // toggle t of stored pattern p: two positions per word
  function automatic logic [12:0] pat_tog(input logic [1:0] p, input logic [1:0] t);
    logic [31:0] w;
    w = mem_reg[6'(vpg_pkg::IX_PAT + {3'b000, p, t[1]})];
    return t[0] ? hi13(w) : lo13(w);
  endfunction

  // apb decode: one aligned word per register, no wait states beyond the access cycle
  assign ix     = paddr[7:2];
  assign mapped = (paddr[1:0] == 2'b00) && (ix <= vpg_pkg::IX_STATUS);
  assign setup  = psel && !penable;
  assign wr_go  = psel && penable && pready_reg && pwrite && mapped && (ix != vpg_pkg::IX_STATUS);

  // read value; status shows the line phase, outputs and group A repetition
  always_comb begin
    rd_word = vpg_pkg::RST_WORD;
    if (mapped && ix == vpg_pkg::IX_STATUS) rd_word = {3'b000, a_rep_idx, vout_reg, 5'b00000, phase_reg, line_odd_reg};
    else if (mapped) rd_word = mem_reg[ix] & wmask(ix);
  end

  // answer in the first access cycle; read data are taken at the setup edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= vpg_pkg::RST_WORD;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= setup;
      pslverr_reg <= setup && (!mapped || (pwrite && ix == vpg_pkg::IX_STATUS));
      if (setup && !pwrite) prdata_reg <= rd_word;
    end
  end

  // register storage, written only at the completing access edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < vpg_pkg::NUM_WORDS; i++) begin
        mem_reg[i] <= vpg_pkg::RST_WORD;
      end
    end else if (wr_go) begin
      mem_reg[ix] <= pwdata & wmask(ix);
    end
  end

  // control fields
  always_comb begin
    segment_alternation_mode     = mem_reg[vpg_pkg::IX_CTRL0][vpg_pkg::CTRL_SEGMENT_ALTERNATION_MODE];
    merge    = (mem_reg[vpg_pkg::IX_CTRL0][vpg_pkg::MERGE_LSB +: 4] == vpg_pkg::MERGE_ON);
    flen_en  = mem_reg[vpg_pkg::IX_CTRL0][vpg_pkg::FLEN_LSB +: 4];
    alt_last = mem_reg[vpg_pkg::IX_CTRL0][vpg_pkg::ALT_LSB +: 2];
    if (alt_last == 2'b00) alt_last = 2'b01; // codes 0 and 1 both mean odd/even
    pol      = mem_reg[vpg_pkg::IX_PICK][vpg_pkg::POL_LSB +: vpg_pkg::NUM_OUT];
    for (int g = 0; g < vpg_pkg::NUM_GRP; g++) begin
      pick[g] = mem_reg[vpg_pkg::IX_PICK][2*g +: 2];
    end
    for (int o = 0; o < vpg_pkg::NUM_OUT; o++) begin
      asg[o] = mem_reg[vpg_pkg::IX_ASSIGN][2*o +: 2];
    end
  end

  // select words share storage with the freeze/resume pairs
  always_comb begin
    for (int j = 0; j < 4; j++) begin
      sel_w[j] = {mem_reg[vpg_pkg::IX_FRZ + 2*j + 1][4:0], lo13(mem_reg[vpg_pkg::IX_FRZ + 2*j])};
    end
    sel0   = line_odd_reg ? sel_w[2] : sel_w[0];
    sel1   = line_odd_reg ? sel_w[3] : sel_w[1];
    a_code = {sel0[a_rep_idx[4:0]], sel1[a_rep_idx[4:0]]};
  end

  // mask window; meaningless while the pairs carry select bits
  always_comb begin
    hold = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (pix_reg >= lo13(mem_reg[vpg_pkg::IX_FRZ + 2*i]) && pix_reg < lo13(mem_reg[vpg_pkg::IX_FRZ + 2*i + 1]))
        hold = 1'b1;
    end
    if (segment_alternation_mode) hold = 1'b0;
  end

  // pixel counter, saturating so a missing line pulse cannot wrap into a new start
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) pix_reg <= 13'h0000;
    else if (line_start) pix_reg <= 13'h0000;
    else if (pix_reg != vpg_pkg::POS_MAX) pix_reg <= pix_reg + 13'h0001;
  end

  // line parity and group A multi-line phase
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      line_odd_reg <= 1'b0;
      phase_reg    <= 2'b00;
    end else if (field_start) begin
      line_odd_reg <= 1'b0;
      phase_reg    <= 2'b00;
    end else if (line_start) begin
      line_odd_reg <= !line_odd_reg;
      phase_reg    <= (phase_reg >= alt_last) ? 2'b00 : phase_reg + 2'b01;
    end
  end

  // one sequencer per group
  genvar gi;
  generate
    for (gi = 0; gi < vpg_pkg::NUM_GRP; gi++) begin : g_grp
      localparam int B = int'(vpg_pkg::IX_GRP) + 4 * gi;
      vpg_grp_if gif ();

      // settings: the repetition count changes with line parity (group A: its multi-line phase, fixed in segment alternation), as do group A's toggles there
      always_comb begin
        gif.start    = lo13(mem_reg[B]);
        gif.len      = lo13(mem_reg[B + 1]);
        gif.last_len = hi13(mem_reg[B + 1]);
        gif.last_en  = flen_en[gi];
        gif.reps     = line_odd_reg ? lo13(mem_reg[B + 2]) : hi13(mem_reg[B + 2]);
        gif.tog      = '0;
        for (int t = 0; t < vpg_pkg::TOG_PAT; t++) begin
          gif.tog[t] = pat_tog(pick[gi], 2'(t));
        end
        gif.tog_en   = 16'h000F;
        if (gi == 0) begin
          case (phase_reg)
            2'b00: gif.reps = lo13(mem_reg[B + 2]);
            2'b01: gif.reps = hi13(mem_reg[B + 2]);
            2'b10: gif.reps = lo13(mem_reg[vpg_pkg::IX_A_REP34]);
            2'b11: gif.reps = hi13(mem_reg[vpg_pkg::IX_A_REP34]);
            default: gif.reps = lo13(mem_reg[B + 2]);
          endcase
          if (segment_alternation_mode) begin
            gif.reps    = lo13(mem_reg[B + 2]);
            if (gif.reps > vpg_pkg::SEG_MAX) gif.reps = vpg_pkg::SEG_MAX;
            gif.last_en = 1'b0;
            for (int t = 0; t < vpg_pkg::TOG_PAT; t++) begin
              gif.tog[t] = pat_tog(a_code, 2'(t));
            end
          end else if (merge) begin
            for (int t = 0; t < vpg_pkg::MAX_TOG; t++) begin
              gif.tog[t] = pat_tog(pick[t/4], 2'(t % 4));
            end
            gif.tog_en = 16'hFFFF;
          end
        end
      end

      vpg_grp u_grp (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .pix        (pix_reg),
        .line_start (line_start),
        .hold       (hold),
        .g          (gif.gen)
      );

      assign lvl_v[gi] = gif.level;
      if (gi == 0) begin : g_a
        assign a_rep_idx = gif.rep_idx;
        chk_seg_cap: assert property (@(posedge mclk) disable iff (!rst_n)
          segment_alternation_mode |-> gif.reps <= vpg_pkg::SEG_MAX) else $error("segment count above eighteen");
      end else begin : g_bcd
        chk_rep_alt: assert property (@(posedge mclk) disable iff (!rst_n)
          line_odd_reg |-> gif.reps == mem_reg[B + 2][12:0]) else $error("odd line repetition not used");
      end
    end
  endgenerate

  // routing: merged mode drives every output from group A with group A timing
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      vout_reg <= 8'h00;
    end else begin
      for (int o = 0; o < vpg_pkg::NUM_OUT; o++) begin
        vout_reg[o] <= (merge ? lvl_v[0] : lvl_v[asg[o]]) ^ pol[o];
      end
    end
  end

  // horizontal blanking window chosen by line parity
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hblank_reg <= 1'b0;
    end else if (line_odd_reg) begin
      hblank_reg <= pix_reg >= lo13(mem_reg[vpg_pkg::IX_HB_ODD]) && pix_reg < hi13(mem_reg[vpg_pkg::IX_HB_ODD]);
    end else begin
      hblank_reg <= pix_reg >= lo13(mem_reg[vpg_pkg::IX_HB_EVEN]) && pix_reg < hi13(mem_reg[vpg_pkg::IX_HB_EVEN]);
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign vout    = vout_reg;
  assign hblank  = hblank_reg;

  sequence s_setup;
    psel && !penable;
  endsequence

  chk_apb_ready: assert property (@(posedge mclk) disable iff (!rst_n)
    s_setup |=> pready_reg ##1 !pready_reg) else $error("apb answer not in first access cycle");
  chk_no_mask: assert property (@(posedge mclk) disable iff (!rst_n)
    segment_alternation_mode |-> !hold) else $error("mask active in segment alternation");
  chk_sel_code: assert property (@(posedge mclk) disable iff (!rst_n)
    (segment_alternation_mode && !line_odd_reg && a_rep_idx == 13'h0000) |-> a_code == {mem_reg[28][0], mem_reg[30][0]})
    else $error("segment code not from even select bits");
  chk_hblank_odd: assert property (@(posedge mclk) disable iff (!rst_n)
    (line_odd_reg && pix_reg >= mem_reg[37][12:0] && pix_reg < mem_reg[37][28:16]) |=> hblank_reg)
    else $error("odd blanking window missed");

  genvar oi;
  generate
    for (oi = 0; oi < vpg_pkg::NUM_OUT; oi++) begin : g_chk
      chk_route_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (!merge && asg[oi] == 2'b00) |=> vout_reg[oi] == ($past(lvl_v[0]) ^ $past(pol[oi])))
        else $error("group A output not following group A");
      chk_merge_route: assert property (@(posedge mclk) disable iff (!rst_n)
        merge |=> vout_reg[oi] == ($past(lvl_v[0]) ^ $past(pol[oi])))
        else $error("merged output not from group A");
    end
  endgenerate
endmodule

// ### hdl/vpg_pkg.sv
// vpg_pkg: register map, field positions, reset values and types of the vertical pattern group combiner
// assumes: compiled first; users never import it and always write vpg_pkg::name
package vpg_pkg;
  // sizes
  localparam int NUM_OUT   = 8;
  localparam int NUM_GRP   = 4;
  localparam int TOG_PAT   = 4;
  localparam int MAX_TOG   = 16;
  localparam int POS_W     = 13;
  localparam int SEL_W     = 18;
  localparam int NUM_WORDS = 38;
  localparam logic [12:0] SEG_MAX = 13'h0012;
  localparam logic [12:0] POS_MAX = 13'h1FFF;
  // word indices, byte address is four times the index
  localparam logic [5:0] IX_CTRL0   = 6'h00;
  localparam logic [5:0] IX_ASSIGN  = 6'h01;
  localparam logic [5:0] IX_PICK    = 6'h02;
  localparam logic [5:0] IX_A_REP34 = 6'h03;
  localparam logic [5:0] IX_GRP     = 6'h04;
  localparam logic [5:0] IX_PAT     = 6'h14;
  localparam logic [5:0] IX_FRZ     = 6'h1C;
  localparam logic [5:0] IX_HB_EVEN = 6'h24;
  localparam logic [5:0] IX_HB_ODD  = 6'h25;
  localparam logic [5:0] IX_STATUS  = 6'h26;
  // field positions
  localparam int HI_LSB     = 16;
  localparam int POL_LSB    = 8;
  localparam int CTRL_SEGMENT_ALTERNATION_MODE  = 6;
  localparam int MERGE_LSB  = 10;
  localparam int FLEN_LSB   = 16;
  localparam int ALT_LSB    = 20;
  localparam logic [3:0] MERGE_ON = 4'h1;
  // writable bits and reset value
  localparam logic [31:0] MSK_CTRL0 = 32'h003F_3C40;
  localparam logic [31:0] MSK_LO16  = 32'h0000_FFFF;
  localparam logic [31:0] MSK_PAIR  = 32'h1FFF_1FFF;
  localparam logic [31:0] MSK_POS   = 32'h0000_1FFF;
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;
  // per-group sequencer states
  typedef enum logic [2:0] {
    GS_WAIT = 3'b001,
    GS_RUN  = 3'b010,
    GS_DONE = 3'b100
  } vpg_gstate_e;
endpackage

// ### hdl/vpg_grp_if.sv
`timescale 1ns/100ps
// vpg_grp_if: settings into one group sequencer and its level back out
// assumes: the top drives the ctl side combinationally each cycle
interface vpg_grp_if;
  logic [12:0]       start;
  logic [12:0]       len;
  logic [12:0]       last_len;
  logic              last_en;
  logic [12:0]       reps;
  logic [15:0][12:0] tog;
  logic [15:0]       tog_en;
  logic              level;
  logic              active;
  logic [12:0]       rep_idx;
  modport gen (input start, len, last_len, last_en, reps, tog, tog_en, output level, active, rep_idx);
  modport ctl (output start, len, last_len, last_en, reps, tog, tog_en, input level, active, rep_idx);
endinterface

// ### hdl/vpg_grp.sv
`timescale 1ns/100ps
// vpg_grp: one pattern group sequencer, repetitions of a toggle pattern from a start pixel
// assumes: pix counts from zero after line_start; a toggle position of zero is unused
module vpg_grp (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // line timing
  input  wire logic [12:0] pix,
  input  wire logic        line_start,
  input  wire logic        hold,
  // settings in, level out
  vpg_grp_if.gen           g
);
  vpg_pkg::vpg_gstate_e state_reg;
  logic [12:0]          off_reg;
  logic [12:0]          rep_reg;
  logic [12:0]          cur_len;
  logic                 last_rep;
  logic                 seg_end;
  logic                 hit;
  logic                 level_reg;

  function automatic logic tog_hit(input logic [12:0] off, input logic [15:0][12:0] t, input logic [15:0] en);
    logic r;
    r = 1'b0;
    for (int i = 0; i < vpg_pkg::MAX_TOG; i++) begin
      if (en[i] && t[i] != 13'h0000 && t[i] == off) r = 1'b1;
    end
    return r;
  endfunction

  // length of the running repetition; the last one may use its own length
  always_comb begin
    last_rep = (rep_reg == g.reps - 13'h0001);
    cur_len  = (last_rep && g.last_en) ? g.last_len : g.len;
    seg_end  = (off_reg == cur_len - 13'h0001);
    hit      = tog_hit(off_reg, g.tog, g.tog_en);
  end

  // repetition sequencing; the offset keeps running under a mask, unlike a hold area
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= vpg_pkg::GS_WAIT;
      off_reg   <= 13'h0000;
      rep_reg   <= 13'h0000;
    end else if (line_start) begin
      state_reg <= vpg_pkg::GS_WAIT;
      off_reg   <= 13'h0000;
      rep_reg   <= 13'h0000;
    end else begin
      case (state_reg)
        vpg_pkg::GS_WAIT: begin
          if (pix == g.start && g.reps != 13'h0000 && g.len != 13'h0000) state_reg <= vpg_pkg::GS_RUN;
        end
        vpg_pkg::GS_RUN: begin
          if (seg_end) begin
            off_reg <= 13'h0000;
            if (last_rep) state_reg <= vpg_pkg::GS_DONE;
            else rep_reg <= rep_reg + 13'h0001;
          end else begin
            off_reg <= off_reg + 13'h0001;
          end
        end
        vpg_pkg::GS_DONE: begin
          state_reg <= vpg_pkg::GS_DONE;
        end
        default: begin
          state_reg <= vpg_pkg::GS_WAIT;
        end
      endcase
    end
  end

  // output level; toggles inside a mask window are dropped, not deferred
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) level_reg <= 1'b0;
    else if (line_start) level_reg <= 1'b0;
    else if (state_reg == vpg_pkg::GS_RUN && hit && !hold) level_reg <= !level_reg;
  end

  assign g.level   = level_reg;
  assign g.active  = (state_reg == vpg_pkg::GS_RUN);
  assign g.rep_idx = rep_reg;

  sequence s_last_step;
    state_reg == vpg_pkg::GS_RUN && seg_end && last_rep && !line_start;
  endsequence

  chk_last_done: assert property (@(posedge mclk) disable iff (!rst_n)
    s_last_step |=> state_reg == vpg_pkg::GS_DONE) else $error("sequencer did not stop after last repetition");
  chk_rep_bound: assert property (@(posedge mclk) disable iff (!rst_n)
    state_reg == vpg_pkg::GS_RUN |-> rep_reg < g.reps) else $error("repetition index beyond count");
  chk_hold_freeze: assert property (@(posedge mclk) disable iff (!rst_n)
    (hold && !line_start) |=> $stable(level_reg)) else $error("level moved inside mask window");
  chk_final_len: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_reg == vpg_pkg::GS_RUN && last_rep && g.last_en && off_reg == g.last_len - 13'h0001 && !line_start)
    |=> state_reg == vpg_pkg::GS_DONE) else $error("final repetition did not use final length");
endmodule

// ### dv/vpg_vdrv_model.sv
`timescale 1ns/100ps
// vpg_vdrv_model: stand-in for the vertical driver channels, tallying pulses per line
// assumes: line_start is the same one-cycle pulse that the combiner sees
module vpg_vdrv_model (
  // clock and line pulse
  input  wire logic            mclk,
  input  wire logic            line_start,
  // from the combiner
  input  wire logic [7:0]      vout,
  input  wire logic            hblank,
  // per-line tallies
  output logic      [7:0][7:0] rises,
  output logic      [7:0]      hb_cnt
);
  logic [7:0] vout_prev = 8'h00;
  // rising edges only: the level reset at a line start can then never count as a pulse on an output with its pol bit clear
  always @(posedge mclk) begin
    vout_prev <= vout;
    for (int i = 0; i < 8; i++) begin
      rises[i] <= line_start ? 8'h00 : rises[i] + 8'(vout[i] & ~vout_prev[i]);
    end
    hb_cnt <= line_start ? 8'h00 : hb_cnt + 8'(hblank);
  end
endmodule

// ### dv/test_vpg_top.sv
`timescale 1ns/100ps
// test_vpg_top: routing, merge, segment alternation, line alternation and final length
// assumes: vpg_top at 10 MHz; the driver model counts pulses between line starts
module test_vpg_top;
  localparam logic [3:0][17:0] SW = {18'h0_FF33, 18'h3_E001, 18'h3_3C0F, 18'h2_5A5A};
  logic            mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic      [7:0] paddr = 8'h00;
  logic     [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic            pready, pslverr, er, hblank, line_start = 1'b0, field_start = 1'b0;
  logic      [7:0] vout, hb_cnt;
  logic [7:0][7:0] rises;
  int              failures = 0, checked = 0;
  always #50 mclk = ~mclk;
  vpg_top uut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .line_start(line_start),
    .field_start(field_start), .vout(vout), .hblank(hblank));
  vpg_vdrv_model far (.mclk(mclk), .line_start(line_start), .vout(vout), .hblank(hblank), .rises(rises),
    .hb_cnt(hb_cnt));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; the request holds until pready is sampled high, only the watchdog bounds the wait
  task automatic apb(input logic wr, input logic [5:0] ix, input logic [31:0] d);
    @(posedge mclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, ix, 2'b00, d};
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic w(input logic [5:0] ix, input logic [31:0] d);
    apb(1'b1, ix, d);
  endtask
  task automatic grp(input int g, input logic [12:0] st, ln, fl, lo, hi);
    w(6'(4 + 4 * g), {19'h0, st});
    w(6'(5 + 4 * g), {3'h0, fl, 3'h0, ln});
    w(6'(6 + 4 * g), {3'h0, hi, 3'h0, lo});
  endtask
  task automatic pat(input int p, input logic [12:0] t0, t1, t2, t3);
    w(6'(20 + 2 * p), {3'h0, t1, 3'h0, t0});
    w(6'(21 + 2 * p), {3'h0, t3, 3'h0, t2});
  endtask
  // one line: start pulse (with field start on the first), then a fixed span of pixels
  task automatic line(input logic first, input int n);
    @(posedge mclk);
    {line_start, field_start} <= {1'b1, first};
    @(posedge mclk);
    {line_start, field_start} <= 2'b00;
    repeat (n) @(posedge mclk);
  endtask
  // pulses per segment pattern a..d are 1, 2, 0, 1; the sum tells whether each code picked its pattern
  function automatic logic [31:0] seg_rises(input logic [17:0] s0, input logic [17:0] s1);
    logic [3:0][7:0] c;
    c = {8'h01, 8'h00, 8'h02, 8'h01};
    seg_rises = 32'h0000_0000;
    for (int k = 0; k < 18; k++) seg_rises = seg_rises + c[{s0[k], s1[k]}];
  endfunction
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // hang guard, far beyond the 1500 or so cycles the tests need
  initial begin
    repeat (20000) @(posedge mclk);
    failures = failures + 1;
    end_of_test;
  end
  // main sequence
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    apb(1'b0, vpg_pkg::IX_ASSIGN, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    w(vpg_pkg::IX_CTRL0, 32'hFFFF_FFFF);
    apb(1'b0, vpg_pkg::IX_CTRL0, 32'h0000_0000);
    chk(rd, vpg_pkg::MSK_CTRL0);
    apb(1'b0, 6'h27, 32'h0000_0000);
    chk({31'h0, er}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    w(vpg_pkg::IX_STATUS, 32'h0000_0001);
    chk({31'h0, er}, 32'h0000_0001);
    $display("test registers done");
    pat(0, 13'h0002, 13'h0005, 13'h0000, 13'h0000);
    pat(1, 13'h0003, 13'h0004, 13'h0000, 13'h0000);
    grp(0, 13'h0001, 13'h0008, 13'h0008, 13'h0001, 13'h0002);
    grp(1, 13'h0001, 13'h0008, 13'h0008, 13'h0003, 13'h0001);
    w(vpg_pkg::IX_A_REP34, 32'h0000_0003);
    w(vpg_pkg::IX_ASSIGN, 32'h0000_0100);
    w(vpg_pkg::IX_PICK, 32'h0000_0004);
    w(vpg_pkg::IX_HB_EVEN, 32'h0014_000A);
    w(vpg_pkg::IX_HB_ODD, 32'h0032_001E);
    w(vpg_pkg::IX_CTRL0, 32'h002F_0000);
    for (int l = 0; l < 4; l++) begin
      line(l == 0, 100);
      chk({24'h0, rises[0]}, l == 2 ? 32'h3 : l == 1 ? 32'h2 : 32'h1);
      chk({24'h0, rises[4]}, l % 2 == 1 ? 32'h3 : 32'h1);
      chk({24'h0, hb_cnt}, l % 2 == 1 ? 32'h14 : 32'h0A);
    end
    apb(1'b0, vpg_pkg::IX_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    $display("test groups and line alternation done");
    pat(0, 13'h0001, 13'h0002, 13'h0000, 13'h0000);
    pat(2, 13'h0005, 13'h0006, 13'h0000, 13'h0000);
    pat(3, 13'h0007, 13'h0008, 13'h0000, 13'h0000);
    grp(0, 13'h0001, 13'h000A, 13'h000A, 13'h0002, 13'h0002);
    w(vpg_pkg::IX_PICK, 32'h0000_80E4);
    w(vpg_pkg::IX_CTRL0, 32'h000F_0400);
    line(1'b1, 100);
    chk({24'h0, rises[0]}, 32'h0000_0008);
    chk({24'h0, rises[4]}, 32'h0000_0008);
    chk({31'h0, vout[7]}, 32'h0000_0001);
    w(vpg_pkg::IX_PICK, 32'h0000_8054);
    line(1'b1, 100);
    chk({24'h0, rises[0]}, 32'h0000_0004);
    $display("test group merge done");
    pat(1, 13'h0001, 13'h0002, 13'h0003, 13'h0004);
    pat(2, 13'h0000, 13'h0000, 13'h0000, 13'h0000);
    pat(3, 13'h0002, 13'h0003, 13'h0000, 13'h0000);
    for (int g = 0; g < 4; g++) grp(g, 13'h0002, 13'h0006, 13'h0006, 13'h0014, 13'h0014);
    for (int j = 0; j < 4; j++) begin
      w(6'(vpg_pkg::IX_FRZ + 2 * j), {19'h0, SW[j][12:0]});
      w(6'(vpg_pkg::IX_FRZ + 2 * j + 1), {27'h0, SW[j][17:13]});
    end
    w(vpg_pkg::IX_CTRL0, 32'h0000_0040);
    line(1'b1, 150);
    chk({24'h0, rises[0]}, seg_rises(SW[0], SW[1]));
    line(1'b0, 150);
    chk({24'h0, rises[0]}, seg_rises(SW[2], SW[3]));
    $display("test segment alternation done");
    w(6'(vpg_pkg::IX_FRZ + 4), 32'h0000_0000);
    w(6'(vpg_pkg::IX_FRZ + 5), 32'h0000_0000);
    pat(0, 13'h0002, 13'h0005, 13'h0000, 13'h0000);
    grp(0, 13'h0001, 13'h000A, 13'h0003, 13'h0002, 13'h0002);
    w(vpg_pkg::IX_CTRL0, 32'h0001_0000);
    line(1'b1, 100);
    chk({31'h0, vout[0]}, 32'h0000_0001);
    w(vpg_pkg::IX_CTRL0, 32'h0000_0000);
    line(1'b1, 100);
    chk({16'h0, rises[0], 7'h0, vout[0]}, 32'h0000_0200);
    w(vpg_pkg::IX_FRZ, 32'h0000_0001);
    w(6'(vpg_pkg::IX_FRZ + 1), 32'h0000_1FFF);
    line(1'b1, 100);
    chk({24'h0, rises[0]}, 32'h0000_0000);
    $display("test final length and masking done");
    end_of_test;
  end
endmodule
